// ### rtl/csis_chg_flag.v
// Sticky change-of-state flag with write-one-to-clear.
// Assumes lvl_i is already in the clk_i domain.
`timescale 1ns/1ps
module csis_chg_flag #(
   parameter RST_VAL = 1'b0
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire lvl_i,
   input wire clr_i,
   output reg flag_o
);
   reg prev_q;
   wire chg;

   assign chg = lvl_i ^ prev_q;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_q <= 1'b0;
         flag_o <= RST_VAL;
      end else if (ce_i) begin
         prev_q <= lvl_i;
         // A change in the clearing cycle still sets the flag
         if (chg) begin
            flag_o <= 1'b1;
         end else if (clr_i) begin
            flag_o <= 1'b0;
         end
      end
   end
endmodule // csis_chg_flag

// ### rtl/csis_regs.vh
// Offsets, field positions, reset values for the channel status/summary block.
// Assumes an 8-bit register port with byte addresses as printed.
// Contract
// - Input two summary bit is its change flag AND its enable.
// - Input one summary bit is its change flag AND its enable.
// - Output summary bits 2..0 follow each output's enabled latched status.
// - Analog PLL summary bit 0 set while any enabled lock-change flag is set.
// - Digital PLL summary bit 0 set while any enabled latched flag is set.
// - Second lock-change flag sets on any change, clears on write of one.
// - Second lock-change flag with enable forwards a channel interrupt request.
// - First lock-change flag sets on any change; write one clears, zero ignored.
// - First lock-change enable gates that flag's interrupt request.
// - Combined lock bit is live AND of analog and digital PLL lock.
// - Highest-priority valid reference field, 00 none, 01/10/11 inputs.
// - Selected reference field in low bits, same encoding.
// - Inputs marked invalid never appear in priority fields; the selected field is gated only by input_validation_control_i.
// - Nonrevertive mode may leave selection differing from highest priority.
// - Second and third priority references at bits 1..0 and 5..4.
// - Overflow flag latches on overflowed measurement, zero when value valid.
// - Top summary bits follow any bit of their lower summary registers.
// - Validity change flags set on change, write one clears, stay until next.
`ifndef CSIS_REGS_VH
`define CSIS_REGS_VH

`define CSIS_ADDR_W 8
`define CSIS_DATA_W 8

`define CSIS_OFS_TOP 8'h42
`define CSIS_OFS_ICSUM 8'h44
`define CSIS_OFS_OCSUM 8'h45
`define CSIS_OFS_APSUM 8'h46
`define CSIS_OFS_DPSUM 8'h47
`define CSIS_OFS_APLOCK 8'h48
`define CSIS_OFS_PRIORITY_TABLE_FIRST 8'h49
`define CSIS_OFS_PRIORITY_TABLE_SECOND 8'h4A
`define CSIS_OFS_MEAS1 8'h4B
`define CSIS_OFS_VAL1 8'h4E
`define CSIS_OFS_VAL2 8'h4F

// analog_pll_lock_status fields
`define CSIS_B_ALK 0
`define CSIS_B_ANALOG_LOCK_PRIMARY_CHANGE 1
`define CSIS_B_ANALOG_LOCK_PRIMARY_IRQ_EN 2
`define CSIS_B_BOTH_PLLS_LOCKED 3
`define CSIS_B_ANALOG_LOCK_SECONDARY 4
`define CSIS_B_ANALOG_LOCK_SECONDARY_CHANGE 5
`define CSIS_B_ANALOG_LOCK_SECONDARY_IRQ_EN 6

// input validity fields (low register: input one at 0, input two at 4)
`define CSIS_B_V1 0
`define CSIS_B_V1L 1
`define CSIS_B_V1IE 2
`define CSIS_B_V2 4
`define CSIS_B_V2L 5
`define CSIS_B_V2IE 6

// phase_measure_status_upper fields
`define CSIS_B_MEASUREMENT_OVERFLOW 6
`define CSIS_B_RDYIE 5
`define CSIS_B_RDYL 4
`define CSIS_B_BUSY 3

// top_irq_status fields
`define CSIS_B_TOP_OC 5
`define CSIS_B_TOP_IC 4
`define CSIS_B_TOP_DPLL 3
`define CSIS_B_TOP_APLL 2

`define CSIS_RST_VFLAG 1'b1
`define CSIS_RST_LFLAG 1'b0

`define CSIS_REF_NONE 2'b00

`endif

// ### rtl/csis_sync3.v
// Three-stage synchroniser with agreement filter.
// Assumes a level from outside the clk_i domain; ce_i freezes it.
`timescale 1ns/1ps
module csis_sync3 (
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire d_i,
   output reg q_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q_o <= 1'b0;
      end else if (ce_i) begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Only accept once two late stages agree
         if (s2_q == s3_q) begin
            q_o <= s3_q;
         end
      end
   end
endmodule // csis_sync3

// ### rtl/csis_top.v
// Channel status and interrupt-summary registers of one channel.
// Assumes an 8-bit register port on clk_i; lock pins come from the analog PLL
// asynchronously, all other status arrives from logic on clk_i.
`timescale 1ns/1ps
`include "csis_regs.vh"
module csis_top #(
   parameter DPLL_W = 8
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire [`CSIS_ADDR_W-1:0] addr_i,
   input wire wr_en_i,
   input wire [`CSIS_DATA_W-1:0] wdata_i,
   input wire rd_en_i,
   output reg [`CSIS_DATA_W-1:0] rdata_o,
   output reg rdata_valid_o,
   input wire alk_pin_i,
   input wire analog_lock_secondary_pin_i,
   input wire dpll_locked_i,
   input wire [2:0] input_valid_i,
   input wire [2:0] input_validation_control_i,
   input wire [5:0] input_prio_i,
   input wire [1:0] selected_reference_i,
   input wire [2:0] output_status_irq_i,
   input wire [DPLL_W-1:0] digital_pll_latched_first_i,
   input wire [DPLL_W-1:0] digital_pll_latched_second_i,
   input wire [DPLL_W-1:0] digital_pll_enable_first_i,
   input wire [DPLL_W-1:0] digital_pll_enable_second_i,
   input wire meas_done_i,
   input wire meas_ovf_i,
   input wire meas_busy_i,
   input wire [2:0] meas_upper_i,
   output reg [3:0] top_summary_o,
   output reg apll_irq_req_o,
   output reg both_plls_locked_o
);
   // Best usable input: lowest priority value, ties to lower index
   function [1:0] best_ref;
      input [2:0] usable;
      input [5:0] prio;
      reg [1:0] code;
      reg [1:0] bp;
      integer k;
      begin
         code = `CSIS_REF_NONE;
         bp = 2'b11;
         for (k = 2; k >= 0; k = k - 1) begin
            if (usable[k] && (code == `CSIS_REF_NONE || prio[2*k +: 2] <= bp)) begin
               code = k[1:0] + 2'd1;
               bp = prio[2*k +: 2];
            end
         end
         best_ref = code;
      end
   endfunction

   function [2:0] ref_onehot;
      input [1:0] code;
      begin
         case (code)
            2'b01: ref_onehot = 3'b001;
            2'b10: ref_onehot = 3'b010;
            2'b11: ref_onehot = 3'b100;
            default: ref_onehot = 3'b000;
         endcase
      end
   endfunction

   wire analog_lock_primary;
   wire analog_lock_secondary;
   wire analog_lock_primary_change;
   wire analog_lock_secondary_change;
   wire [2:0] vflag;
   wire wr_lock;
   wire wr_v1;
   wire wr_v2;
   wire wr_meas;

   reg analog_lock_primary_irq_en_q;
   reg analog_lock_secondary_irq_en_q;
   reg [2:0] vie_q;
   reg measurement_overflow_q;
   reg rdyl_q;
   reg rdyie_q;

   assign wr_lock = ce_i & wr_en_i & (addr_i == `CSIS_OFS_APLOCK);
   assign wr_v1 = ce_i & wr_en_i & (addr_i == `CSIS_OFS_VAL1);
   assign wr_v2 = ce_i & wr_en_i & (addr_i == `CSIS_OFS_VAL2);
   assign wr_meas = ce_i & wr_en_i & (addr_i == `CSIS_OFS_MEAS1);

   // Lock pins cross from the analog PLL clock
   csis_sync3 u_sync_alk (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .d_i(alk_pin_i),
      .q_o(analog_lock_primary)
   );

   csis_sync3 u_sync_analog_lock_secondary (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .d_i(analog_lock_secondary_pin_i),
      .q_o(analog_lock_secondary)
   );

   csis_chg_flag #(.RST_VAL(`CSIS_RST_LFLAG)) u_analog_lock_primary_change (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .lvl_i(analog_lock_primary),
      .clr_i(wr_lock & wdata_i[`CSIS_B_ANALOG_LOCK_PRIMARY_CHANGE]),
      .flag_o(analog_lock_primary_change)
   );

   csis_chg_flag #(.RST_VAL(`CSIS_RST_LFLAG)) u_analog_lock_secondary_change (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .lvl_i(analog_lock_secondary),
      .clr_i(wr_lock & wdata_i[`CSIS_B_ANALOG_LOCK_SECONDARY_CHANGE]),
      .flag_o(analog_lock_secondary_change)
   );

   csis_chg_flag #(.RST_VAL(`CSIS_RST_VFLAG)) u_v1l (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .lvl_i(input_valid_i[0]),
      .clr_i(wr_v1 & wdata_i[`CSIS_B_V1L]),
      .flag_o(vflag[0])
   );

   csis_chg_flag #(.RST_VAL(`CSIS_RST_VFLAG)) u_v2l (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .lvl_i(input_valid_i[1]),
      .clr_i(wr_v1 & wdata_i[`CSIS_B_V2L]),
      .flag_o(vflag[1])
   );

   csis_chg_flag #(.RST_VAL(`CSIS_RST_VFLAG)) u_v3l (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .lvl_i(input_valid_i[2]),
      .clr_i(wr_v2 & wdata_i[`CSIS_B_V1L]),
      .flag_o(vflag[2])
   );

   // Writable enables only; read-only fields ignore writes
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         analog_lock_primary_irq_en_q <= 1'b0;
         analog_lock_secondary_irq_en_q <= 1'b0;
         vie_q <= 3'b000;
         rdyie_q <= 1'b0;
      end else begin
         if (wr_lock) begin
            analog_lock_primary_irq_en_q <= wdata_i[`CSIS_B_ANALOG_LOCK_PRIMARY_IRQ_EN];
            analog_lock_secondary_irq_en_q <= wdata_i[`CSIS_B_ANALOG_LOCK_SECONDARY_IRQ_EN];
         end
         if (wr_v1) begin
            vie_q[0] <= wdata_i[`CSIS_B_V1IE];
            vie_q[1] <= wdata_i[`CSIS_B_V2IE];
         end
         if (wr_v2) begin
            vie_q[2] <= wdata_i[`CSIS_B_V1IE];
         end
         if (wr_meas) begin
            rdyie_q <= wdata_i[`CSIS_B_RDYIE];
         end
      end
   end

   // Measurement flags: a completion in the clearing cycle wins
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         measurement_overflow_q <= 1'b0;
         rdyl_q <= 1'b0;
      end else if (ce_i) begin
         if (meas_done_i) begin
            measurement_overflow_q <= meas_ovf_i;
            rdyl_q <= 1'b1;
         end else if (wr_meas) begin
            if (wdata_i[`CSIS_B_MEASUREMENT_OVERFLOW]) begin
               measurement_overflow_q <= 1'b0;
            end
            if (wdata_i[`CSIS_B_RDYL]) begin
               rdyl_q <= 1'b0;
            end
         end
      end
   end

   // Summaries stay combinational so a clear shows at once
   wire [2:0] ic_sum;
   wire [2:0] oc_sum;
   wire ap_sum;
   wire dp_sum;
   wire both_plls_locked;

   assign ic_sum[0] = vflag[0] & vie_q[0];
   assign ic_sum[1] = vflag[1] & vie_q[1];
   assign ic_sum[2] = vflag[2] & vie_q[2];
   assign oc_sum = output_status_irq_i;
   assign ap_sum = (analog_lock_primary_change & analog_lock_primary_irq_en_q) | (analog_lock_secondary_change & analog_lock_secondary_irq_en_q);
   assign dp_sum = |((digital_pll_latched_first_i & digital_pll_enable_first_i)
                   | (digital_pll_latched_second_i & digital_pll_enable_second_i));
   assign both_plls_locked = analog_lock_primary & analog_lock_secondary & dpll_locked_i;

   // Priority fields from inputs both valid and permitted
   wire [2:0] usable;
   wire [1:0] highest_priority_reference;
   wire [1:0] second_priority_reference;
   wire [1:0] third_priority_reference;
   wire [1:0] selected_reference;

   assign usable = input_valid_i & input_validation_control_i;
   assign highest_priority_reference = best_ref(usable, input_prio_i);
   assign second_priority_reference = best_ref(usable & ~ref_onehot(highest_priority_reference), input_prio_i);
   assign third_priority_reference = best_ref(usable & ~ref_onehot(highest_priority_reference) & ~ref_onehot(second_priority_reference),
                          input_prio_i);
   // Selection passes through unless its input is not permitted, so nonrevertive mode may differ
   assign selected_reference = (|(ref_onehot(selected_reference_i) & input_validation_control_i))
                   ? selected_reference_i : `CSIS_REF_NONE;

   reg [`CSIS_DATA_W-1:0] rd_mux;
   always @* begin
      rd_mux = 8'h00;
      case (addr_i)
         `CSIS_OFS_TOP: begin
            rd_mux[`CSIS_B_TOP_OC] = |oc_sum;
            rd_mux[`CSIS_B_TOP_IC] = |ic_sum;
            rd_mux[`CSIS_B_TOP_DPLL] = dp_sum;
            rd_mux[`CSIS_B_TOP_APLL] = ap_sum;
         end
         `CSIS_OFS_ICSUM: rd_mux[2:0] = ic_sum;
         `CSIS_OFS_OCSUM: rd_mux[2:0] = oc_sum;
         `CSIS_OFS_APSUM: rd_mux[0] = ap_sum;
         `CSIS_OFS_DPSUM: rd_mux[0] = dp_sum;
         `CSIS_OFS_APLOCK: begin
            rd_mux[`CSIS_B_ALK] = analog_lock_primary;
            rd_mux[`CSIS_B_ANALOG_LOCK_PRIMARY_CHANGE] = analog_lock_primary_change;
            rd_mux[`CSIS_B_ANALOG_LOCK_PRIMARY_IRQ_EN] = analog_lock_primary_irq_en_q;
            rd_mux[`CSIS_B_BOTH_PLLS_LOCKED] = both_plls_locked;
            rd_mux[`CSIS_B_ANALOG_LOCK_SECONDARY] = analog_lock_secondary;
            rd_mux[`CSIS_B_ANALOG_LOCK_SECONDARY_CHANGE] = analog_lock_secondary_change;
            rd_mux[`CSIS_B_ANALOG_LOCK_SECONDARY_IRQ_EN] = analog_lock_secondary_irq_en_q;
         end
         `CSIS_OFS_PRIORITY_TABLE_FIRST: begin
            rd_mux[5:4] = highest_priority_reference;
            rd_mux[1:0] = selected_reference;
         end
         `CSIS_OFS_PRIORITY_TABLE_SECOND: begin
            rd_mux[5:4] = third_priority_reference;
            rd_mux[1:0] = second_priority_reference;
         end
         `CSIS_OFS_MEAS1: begin
            rd_mux[`CSIS_B_MEASUREMENT_OVERFLOW] = measurement_overflow_q;
            rd_mux[`CSIS_B_RDYIE] = rdyie_q;
            rd_mux[`CSIS_B_RDYL] = rdyl_q;
            rd_mux[`CSIS_B_BUSY] = meas_busy_i;
            rd_mux[2:0] = meas_upper_i;
         end
         `CSIS_OFS_VAL1: begin
            rd_mux[`CSIS_B_V1] = input_valid_i[0];
            rd_mux[`CSIS_B_V1L] = vflag[0];
            rd_mux[`CSIS_B_V1IE] = vie_q[0];
            rd_mux[`CSIS_B_V2] = input_valid_i[1];
            rd_mux[`CSIS_B_V2L] = vflag[1];
            rd_mux[`CSIS_B_V2IE] = vie_q[1];
         end
         `CSIS_OFS_VAL2: begin
            rd_mux[`CSIS_B_V1] = input_valid_i[2];
            rd_mux[`CSIS_B_V1L] = vflag[2];
            rd_mux[`CSIS_B_V1IE] = vie_q[2];
         end
         default: rd_mux = 8'h00;
      endcase
   end

   // Outputs registered: one cycle behind the live summaries
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
         rdata_valid_o <= 1'b0;
         top_summary_o <= 4'h0;
         apll_irq_req_o <= 1'b0;
         both_plls_locked_o <= 1'b0;
      end else if (ce_i) begin
         rdata_valid_o <= rd_en_i;
         if (rd_en_i) begin
            rdata_o <= rd_mux;
         end
         top_summary_o <= {|oc_sum, |ic_sum, dp_sum, ap_sum};
         apll_irq_req_o <= ap_sum;
         both_plls_locked_o <= both_plls_locked;
      end
   end
endmodule // csis_top

// ### sim/csis_top_checker.sv
// Port-level assertions for the channel status and interrupt-summary block.
// Assumes one clock domain on clk_i with an asynchronous active-low reset.
`timescale 1ns/1ps
module csis_top_checker #(
   parameter DPLL_W = 8
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire [7:0] addr_i,
   input wire rd_en_i,
   input wire [7:0] rdata_o,
   input wire rdata_valid_o,
   input wire alk_pin_i,
   input wire dpll_locked_i,
   input wire [2:0] output_status_irq_i,
   input wire [DPLL_W-1:0] digital_pll_latched_first_i,
   input wire [DPLL_W-1:0] digital_pll_latched_second_i,
   input wire [DPLL_W-1:0] digital_pll_enable_first_i,
   input wire [DPLL_W-1:0] digital_pll_enable_second_i,
   input wire [3:0] top_summary_o,
   input wire apll_irq_req_o,
   input wire both_plls_locked_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire dpll_any = |((digital_pll_latched_first_i & digital_pll_enable_first_i) |
      (digital_pll_latched_second_i & digital_pll_enable_second_i));
   chk_oc_summary:
   assert property (ce_i |=> top_summary_o[3] == $past(|output_status_irq_i))
      else $error("output summary does not follow output status");
   chk_dpll_summary:
   assert property (ce_i |=> top_summary_o[1] == $past(dpll_any))
      else $error("digital pll summary does not follow its flags");
   chk_both_plls_locked_dpll:
   assert property (ce_i && !dpll_locked_i |=> !both_plls_locked_o)
      else $error("combined lock set without digital lock");
   chk_both_plls_locked_alk:
   assert property ((ce_i && !alk_pin_i) [*6] |=> !both_plls_locked_o)
      else $error("combined lock set without analog lock");
   chk_both_plls_locked_cause:
   assert property ($rose(both_plls_locked_o) |-> $past(dpll_locked_i))
      else $error("combined lock rose without cause");
   chk_apll_request:
   assert property (apll_irq_req_o == top_summary_o[0])
      else $error("analog request differs from analog summary");
   chk_read_answer:
   assert property (ce_i && rd_en_i |=> rdata_valid_o)
      else $error("read not answered");
   chk_read_hold:
   assert property (!rdata_valid_o |-> $stable(rdata_o))
      else $error("read data moved without a read");
   chk_unmapped_read:
   assert property (ce_i && rd_en_i && addr_i[7:4] == 4'h5 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_apll_readback:
   assert property (ce_i && rd_en_i && addr_i == 8'h46 |=> rdata_o[0] == apll_irq_req_o)
      else $error("analog summary read differs from analog request");
   chk_ce_freeze:
   assert property (!ce_i |=> $stable(rdata_o) && $stable(rdata_valid_o)
      && $stable(top_summary_o) && $stable(apll_irq_req_o) && $stable(both_plls_locked_o))
      else $error("outputs moved while clock enable low");
endmodule // csis_top_checker

bind csis_top csis_top_checker #(.DPLL_W(DPLL_W)) csis_top_checker_inst (.*);

// ### sim/tb_csis_top.sv
// Directed bench for the channel status and interrupt-summary block.
// Assumes csis_top alone on its register port, clock enable held high except in t_ce.
`timescale 1ns/1ps
module tb_csis_top;
   reg clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
   reg wr_en_i = 1'b0, rd_en_i = 1'b0;
   reg [7:0] addr_i = 8'h00, wdata_i = 8'h00;
   reg alk_pin_i = 1'b0, analog_lock_secondary_pin_i = 1'b0, dpll_locked_i = 1'b0;
   reg [2:0] input_valid_i = 3'h0, input_validation_control_i = 3'h7;
   reg [5:0] input_prio_i = 6'h12;
   reg [1:0] selected_reference_i = 2'h0;
   reg [2:0] output_status_irq_i = 3'h0, meas_upper_i = 3'h0;
   reg [7:0] digital_pll_latched_first_i = 8'h00, digital_pll_latched_second_i = 8'h00;
   reg [7:0] digital_pll_enable_first_i = 8'h00, digital_pll_enable_second_i = 8'h00;
   reg meas_done_i = 1'b0, meas_ovf_i = 1'b0, meas_busy_i = 1'b0;
   wire [7:0] rdata_o;
   wire rdata_valid_o, apll_irq_req_o, both_plls_locked_o;
   wire [3:0] top_summary_o;
   integer num_errors = 0, n_tests = 0;

   csis_top #(.DPLL_W(8)) csis_top_inst (.*);

   always #5 clk_i = ~clk_i;

   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task idle(input integer n);
      begin
         repeat (n) @(posedge clk_i);
         #1;
      end
   endtask

   // Each access starts a cycle late so no strobe is driven twice in a step
   task wr(input [7:0] a, input [7:0] d);
      begin
         idle(1);
         wr_en_i = 1'b1;
         addr_i = a;
         wdata_i = d;
         idle(1);
         wr_en_i = 1'b0;
      end
   endtask

   task rd(input [7:0] a, input [7:0] exp);
      begin
         idle(1);
         rd_en_i = 1'b1;
         addr_i = a;
         idle(1);
         rd_en_i = 1'b0;
         chk({7'h00, rdata_valid_o}, 8'h01);
         chk(rdata_o, exp);
      end
   endtask

   task done(input ovf);
      begin
         meas_ovf_i = ovf;
         meas_done_i = 1'b1;
         idle(1);
         meas_done_i = 1'b0;
      end
   endtask

   task t_regs;
      integer i;
      begin
         for (i = 5; i < 12; i = i + 1) begin
            rd(8'h40 + i[7:0], 8'h00);
            if (i != 8 && i != 11) begin
               wr(8'h40 + i[7:0], 8'hFF);
               rd(8'h40 + i[7:0], 8'h00);
            end
         end
         wr(8'h48, 8'h99);
         rd(8'h48, 8'h00);
         rd(8'h4E, 8'h22);
         rd(8'h50, 8'h00);
      end
   endtask

   task t_lock;
      begin
         alk_pin_i = 1'b1;
         idle(8);
         rd(8'h48, 8'h03);
         chk({7'h00, apll_irq_req_o}, 8'h00);
         wr(8'h48, 8'h04);
         rd(8'h46, 8'h01);
         rd(8'h48, 8'h07);
         chk({6'h00, apll_irq_req_o, top_summary_o[0]}, 8'h03);
         wr(8'h48, 8'h06);
         rd(8'h48, 8'h05);
         analog_lock_secondary_pin_i = 1'b1;
         dpll_locked_i = 1'b1;
         idle(8);
         rd(8'h48, 8'h3D);
         chk({6'h00, apll_irq_req_o, both_plls_locked_o}, 8'h01);
         wr(8'h48, 8'h44);
         idle(2);
         chk({7'h00, apll_irq_req_o}, 8'h01);
         wr(8'h48, 8'h64);
         idle(2);
         chk({7'h00, apll_irq_req_o}, 8'h00);
         // Flag cleared first so the falling change must set it again
         analog_lock_secondary_pin_i = 1'b0;
         idle(8);
         rd(8'h48, 8'h65);
         wr(8'h48, 8'h64);
         rd(8'h48, 8'h45);
         chk({6'h00, apll_irq_req_o, both_plls_locked_o}, 8'h00);
         wr(8'h48, 8'h00);
      end
   endtask

   task t_inputs;
      begin
         wr(8'h4E, 8'h44);
         rd(8'h44, 8'h03);
         chk({7'h00, top_summary_o[2]}, 8'h01);
         wr(8'h4E, 8'h66);
         wr(8'h4F, 8'h02);
         rd(8'h4E, 8'h44);
         rd(8'h44, 8'h00);
         input_valid_i = 3'h2;
         rd(8'h44, 8'h02);
         rd(8'h4E, 8'h74);
         input_valid_i = 3'h3;
         rd(8'h44, 8'h03);
         wr(8'h4E, 8'h00);
         rd(8'h44, 8'h00);
      end
   endtask

   // Priorities: input two first, then three, then one
   task t_prio;
      begin
         input_valid_i = 3'h7;
         selected_reference_i = 2'h1;
         rd(8'h49, 8'h21);
         rd(8'h4A, 8'h13);
         input_validation_control_i = 3'h6;
         rd(8'h49, 8'h20);
         rd(8'h4A, 8'h03);
         input_valid_i = 3'h5;
         selected_reference_i = 2'h3;
         rd(8'h49, 8'h33);
         rd(8'h4A, 8'h00);
         input_validation_control_i = 3'h0;
         rd(8'h49, 8'h00);
      end
   endtask

   task t_sums;
      begin
         output_status_irq_i = 3'h5;
         digital_pll_latched_first_i = 8'h80;
         rd(8'h45, 8'h05);
         rd(8'h47, 8'h00);
         digital_pll_enable_first_i = 8'h80;
         rd(8'h47, 8'h01);
         chk({4'h0, top_summary_o}, 8'h0A);
         digital_pll_latched_first_i = 8'h00;
         digital_pll_latched_second_i = 8'h01;
         digital_pll_enable_second_i = 8'h01;
         output_status_irq_i = 3'h0;
         rd(8'h47, 8'h01);
         digital_pll_enable_second_i = 8'h00;
         rd(8'h47, 8'h00);
         rd(8'h45, 8'h00);
      end
   endtask

   task t_meas;
      begin
         meas_upper_i = 3'h5;
         meas_busy_i = 1'b1;
         rd(8'h4B, 8'h0D);
         meas_busy_i = 1'b0;
         done(1'b1);
         rd(8'h4B, 8'h55);
         done(1'b0);
         rd(8'h4B, 8'h15);
         wr(8'h4B, 8'h10);
         rd(8'h4B, 8'h05);
      end
   endtask

   // Write while the clock enable is low must be lost
   task t_ce;
      begin
         ce_i = 1'b0;
         wr(8'h48, 8'h44);
         idle(1);
         ce_i = 1'b1;
         rd(8'h48, 8'h01);
      end
   endtask

   task final_report;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, num_errors);
         if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   initial begin
      idle(20);
      rst_n_i = 1'b1;
      t_regs;
      t_lock;
      t_inputs;
      t_prio;
      t_sums;
      t_meas;
      t_ce;
      final_report;
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      #100000;
      num_errors = num_errors + 1;
      final_report;
   end
endmodule // tb_csis_top
